// ===== core/coil_pkg.sv
package coil_pkg;

    // ****************************************************************
    // Element space
    // ****************************************************************
    localparam int          NUM_ELEM      = 57;
    localparam int          SNAP_W        = 128;

    // ****************************************************************
    // Function and exception codes
    // ****************************************************************
    localparam logic [7:0]  FUNC_READ_COIL = 8'h01;
    localparam logic [7:0]  EXC_NONE       = 8'h00;
    localparam logic [7:0]  EXC_BAD_FUNC   = 8'h01;
    localparam logic [7:0]  EXC_BAD_ADDR   = 8'h02;

    // ****************************************************************
    // Coil map, zero-based wire addresses
    // ****************************************************************
    // Live coils 00001 to 00057.
    localparam logic [15:0] RT_FIRST_ADDR = 16'h0000;
    localparam logic [15:0] RT_LAST_ADDR  = 16'h0038;
    // Change-detect pairs, coils 02048 to 02161.
    localparam logic [15:0] CD_FIRST_ADDR = 16'h07ff;
    localparam logic [15:0] CD_LAST_ADDR  = 16'h0870;

    // ****************************************************************
    // Change counter values and reset values
    // ****************************************************************
    localparam logic [1:0]  CNT_NONE      = 2'h0;
    localparam logic [1:0]  CNT_ONE       = 2'h1;
    localparam logic [1:0]  CNT_MANY      = 2'h2;
    localparam logic [7:0]  REMAIN_RESET  = 8'h00;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_STREAM
    } reply_state_type;

endpackage : coil_pkg

// ===== core/coil_status_change_detect.sv
`timescale 1ns/1ps
module coil_status_change_detect (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Monitored elements and their configuration
    input  wire logic [56:0] elementPin,
    input  wire logic [56:0] latchEnable,
    // Local keypad
    input  wire logic        keyClearPin,
    input  wire logic        keyEnterPin,
    // Remote latch reset
    input  wire logic        remoteClearValid,
    input  wire logic [56:0] remoteClearMask,
    // Request from the protocol engine
    input  wire logic        reqValid,
    input  wire logic [7:0]  reqFunction,
    input  wire logic [15:0] reqStart,
    input  wire logic [15:0] reqCount,
    output logic             reqReady,
    // Reply to the protocol engine
    output logic             rspValid,
    output logic             rspBit,
    output logic             rspLast,
    output logic             rspException,
    output logic [7:0]       rspExceptionCode
);

    // ****************************************************************
    // Request decode
    // ****************************************************************
    function automatic logic inRange(input logic [15:0] s,
                                     input logic [15:0] c,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
        logic [16:0] last;
        last = {1'b0, s} + {1'b0, c} - 17'h00001;
        inRange = (c != 16'h0000) && (s >= lo) && (last <= {1'b0, hi});
    endfunction : inRange

    function automatic logic [7:0] checkReq(input logic [7:0]  f,
                                            input logic [15:0] s,
                                            input logic [15:0] c);
        logic [15:0] off;
        off = s - coil_pkg::CD_FIRST_ADDR;
        if (f != coil_pkg::FUNC_READ_COIL) begin
            checkReq = coil_pkg::EXC_BAD_FUNC;
        end else if (inRange(s, c, coil_pkg::RT_FIRST_ADDR,
                             coil_pkg::RT_LAST_ADDR)) begin
            checkReq = coil_pkg::EXC_NONE;
        end else if (inRange(s, c, coil_pkg::CD_FIRST_ADDR,
                             coil_pkg::CD_LAST_ADDR)
                     && !off[0] && !c[0]) begin
            checkReq = coil_pkg::EXC_NONE;
        end else begin
            checkReq = coil_pkg::EXC_BAD_ADDR;
        end
    endfunction : checkReq

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [56:0] elemMeta_reg;
    logic [56:0] elemSync_reg;
    logic [56:0] elemPrev_reg;
    logic [1:0]  keyMeta_reg;
    logic [1:0]  keySync_reg;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            elemMeta_reg <= '0;
            elemSync_reg <= '0;
            elemPrev_reg <= '0;
            keyMeta_reg  <= 2'h0;
            keySync_reg  <= 2'h0;
        end else begin
            elemMeta_reg <= elementPin;
            elemSync_reg <= elemMeta_reg;
            elemPrev_reg <= elemSync_reg;
            keyMeta_reg  <= {keyEnterPin, keyClearPin};
            keySync_reg  <= keyMeta_reg;
        end
    end

    // ****************************************************************
    // Accept and range of the pairs being read
    // ****************************************************************
    coil_pkg::reply_state_type state_reg;
    logic        accept;
    logic [7:0]  excCode;
    logic        isCd;
    logic [15:0] cdOff;
    logic [15:0] rtOff;
    logic [15:0] pairLo;
    logic [15:0] pairHi;
    logic        keysBoth;

    assign accept   = reqValid && reqReady;
    assign excCode  = checkReq(reqFunction, reqStart, reqCount);
    assign isCd     = reqStart >= coil_pkg::CD_FIRST_ADDR;
    assign cdOff    = reqStart - coil_pkg::CD_FIRST_ADDR;
    assign rtOff    = reqStart - coil_pkg::RT_FIRST_ADDR;
    assign pairLo   = {1'b0, cdOff[15:1]};
    assign pairHi   = pairLo + {1'b0, reqCount[15:1]} - 16'h0001;
    assign keysBoth = keySync_reg[0] && keySync_reg[1];

    // ****************************************************************
    // Per-element change counting and latching
    // ****************************************************************
    logic [1:0]  transCount_reg [coil_pkg::NUM_ELEM];
    logic [56:0] latched_reg;
    logic [56:0] momentary;
    logic [56:0] rtVec;
    logic [113:0] pairVec;

    genvar gi;
    generate
        for (gi = 0; gi < coil_pkg::NUM_ELEM; gi++) begin : g_elem
            logic trans;
            logic pairRead;
            logic latchClear;
            assign trans    = elemSync_reg[gi] != elemPrev_reg[gi];
            assign pairRead = accept && excCode == coil_pkg::EXC_NONE
                              && isCd && 16'(gi) >= pairLo
                              && 16'(gi) <= pairHi;
            assign latchClear = keysBoth
                || (remoteClearValid && remoteClearMask[gi]);

            // A change in the same cycle as the read survives the clear.
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    transCount_reg[gi] <= coil_pkg::CNT_NONE;
                end else if (pairRead) begin
                    transCount_reg[gi] <= trans ? coil_pkg::CNT_ONE
                                                : coil_pkg::CNT_NONE;
                end else if (trans
                             && transCount_reg[gi] != coil_pkg::CNT_MANY) begin
                    transCount_reg[gi] <= transCount_reg[gi] + 2'h1;
                end
            end

            // Set on a rising element outranks a keypad or remote clear in that cycle; a low latchEnable outranks the set.
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    latched_reg[gi] <= 1'b0;
                end else if (!latchEnable[gi]) begin
                    latched_reg[gi] <= 1'b0;
                end else if (elemSync_reg[gi] && !elemPrev_reg[gi]) begin
                    latched_reg[gi] <= 1'b1;
                end else if (latchClear) begin
                    latched_reg[gi] <= 1'b0;
                end
            end

            assign momentary[gi] = transCount_reg[gi] == coil_pkg::CNT_MANY;
            assign rtVec[gi] = latchEnable[gi]
                             ? (latched_reg[gi] || elemSync_reg[gi])
                             : elemSync_reg[gi];
            assign pairVec[2*gi]   = momentary[gi];
            assign pairVec[2*gi+1] = elemSync_reg[gi];
        end
    endgenerate

    // ****************************************************************
    // Reply sequencer
    // ****************************************************************
    logic [coil_pkg::SNAP_W-1:0] snap_reg;
    logic [7:0]                  remain_reg;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_reg        <= coil_pkg::ST_IDLE;
            snap_reg         <= '0;
            remain_reg       <= coil_pkg::REMAIN_RESET;
            reqReady         <= 1'b0;
            rspValid         <= 1'b0;
            rspBit           <= 1'b0;
            rspLast          <= 1'b0;
            rspException     <= 1'b0;
            rspExceptionCode <= coil_pkg::EXC_NONE;
        end else begin
            unique case (state_reg)
                coil_pkg::ST_IDLE: begin
                    reqReady     <= 1'b1;
                    rspValid     <= 1'b0;
                    rspLast      <= 1'b0;
                    rspBit       <= 1'b0;
                    rspException <= 1'b0;
                    if (accept && excCode != coil_pkg::EXC_NONE) begin
                        rspValid         <= 1'b1;
                        rspLast          <= 1'b1;
                        rspException     <= 1'b1;
                        rspExceptionCode <= excCode;
                    end else if (accept) begin
                        rspExceptionCode <= coil_pkg::EXC_NONE;
                        reqReady   <= 1'b0;
                        remain_reg <= reqCount[7:0];
                        state_reg  <= coil_pkg::ST_STREAM;
                        snap_reg   <= isCd
                            ? ({14'h0000, pairVec} >> cdOff[6:0])
                            : ({71'h0, rtVec} >> rtOff[6:0]);
                    end
                end
                coil_pkg::ST_STREAM: begin
                    rspValid   <= 1'b1;
                    rspBit     <= snap_reg[0];
                    snap_reg   <= snap_reg >> 1;
                    remain_reg <= remain_reg - 8'h01;
                    rspLast    <= remain_reg == 8'h01;
                    if (remain_reg == 8'h01) begin
                        state_reg <= coil_pkg::ST_IDLE;
                        reqReady  <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_bad_function: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        accept && reqFunction != coil_pkg::FUNC_READ_COIL
        |=> rspValid && rspException && rspLast
            && rspExceptionCode == coil_pkg::EXC_BAD_FUNC)
        else $error("unsupported function not refused");

    a_bad_address: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        accept && reqFunction == coil_pkg::FUNC_READ_COIL
        && reqStart > coil_pkg::RT_LAST_ADDR
        && reqStart < coil_pkg::CD_FIRST_ADDR
        |=> rspException && rspExceptionCode == coil_pkg::EXC_BAD_ADDR)
        else $error("undefined address not refused");

    a_two_bit_read: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        accept && excCode == coil_pkg::EXC_NONE && reqCount == 16'h0002
        |=> ##1 rspValid && !rspLast && !rspException
            ##1 rspValid && rspLast ##1 !rspValid && reqReady)
        else $error("two-bit read has wrong length");

    a_live_snapshot: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        accept && excCode == coil_pkg::EXC_NONE && !isCd
        && reqStart == coil_pkg::RT_FIRST_ADDR
        |=> ##1 rspBit == $past(rtVec[0], 2))
        else $error("live coil differs from state at service");

    a_pair_status: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        accept && excCode == coil_pkg::EXC_NONE && isCd
        && reqStart == coil_pkg::CD_FIRST_ADDR
        |=> ##1 rspBit == $past(momentary[0], 2)
            ##1 rspBit == $past(elemSync_reg[0], 3))
        else $error("pair bits out of order");

    a_many_changes: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        $past(elemSync_reg[0]) != $past(elemPrev_reg[0])
        && $past(transCount_reg[0]) == coil_pkg::CNT_ONE
        && !$past(g_elem[0].pairRead)
        |-> momentary[0])
        else $error("second change not flagged");

    a_read_clears: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        g_elem[0].pairRead && !g_elem[0].trans
        |=> transCount_reg[0] == coil_pkg::CNT_NONE)
        else $error("read did not clear indication");

    a_other_pairs_kept: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !g_elem[56].pairRead && momentary[56]
        |=> momentary[56])
        else $error("unread pair lost its indication");

    a_latch_holds: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        latched_reg[0] && latchEnable[0] && !g_elem[0].latchClear
        |=> latched_reg[0])
        else $error("latched point dropped without reset");

    a_latch_sets: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        elemSync_reg[0] && !elemPrev_reg[0] && latchEnable[0]
        |=> latched_reg[0])
        else $error("rising element not latched");

    a_keypad_clear: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        keysBoth && !(elemSync_reg[0] && !elemPrev_reg[0])
        |=> !latched_reg[0])
        else $error("keypad did not clear latch");

endmodule : coil_status_change_detect

// ===== testbench/coil_host_model.sv
`timescale 1ns/1ps
module coil_host_model (
    // Clock and handshake
    input  wire logic        sys_clk,
    input  wire logic        reqReady,
    // Request
    output logic             reqValid,
    output logic [7:0]       reqFunction,
    output logic [15:0]      reqStart,
    output logic [15:0]      reqCount,
    // Remote latch reset
    output logic             remoteClearValid,
    output logic [56:0]      remoteClearMask
);
    initial begin
        reqValid         = 1'b0;
        reqFunction      = 8'h00;
        reqStart         = 16'h0000;
        reqCount         = 16'h0000;
        remoteClearValid = 1'b0;
        remoteClearMask  = 57'h0;
    end

    // checksum upstream
    // Framing and checksums live above this boundary, so no check here.
    // pairs kept by caller
    task automatic read(input logic [7:0] fn, input logic [15:0] st,
                        input logic [15:0] n);
        @(negedge sys_clk);
        reqValid    <= 1'b1;
        reqFunction <= fn;
        reqStart    <= st;
        reqCount    <= n;
        while (reqReady !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk);
        // Released fields are scrambled so stale values are never trusted.
        reqValid    <= 1'b0;
        reqFunction <= ~fn;
        reqStart    <= ~st;
        reqCount    <= ~n;
    endtask : read

    task automatic clear_bits(input logic [56:0] mask);
        @(negedge sys_clk);
        remoteClearValid <= 1'b1;
        remoteClearMask  <= mask;
        @(negedge sys_clk);
        remoteClearValid <= 1'b0;
        remoteClearMask  <= ~mask;
    endtask : clear_bits
endmodule : coil_host_model

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic       exc;
        logic       bitVal;
        logic       last;
        logic [7:0] code;
    } note_type;

    logic        sys_clk, resetn, keyClearPin, keyEnterPin, reqReady;
    logic [56:0] elementPin, latchEnable, remoteClearMask, cur, lat;
    logic        reqValid, remoteClearValid, rspValid, rspBit, rspLast;
    logic        rspException;
    logic [7:0]  reqFunction, rspExceptionCode;
    logic [15:0] reqStart, reqCount;
    logic [63:0] r;
    note_type    notes[$];
    note_type    got;
    int          fail_count, checks, cycles, seed, i, k;
    int          cnt[57];
    logic [7:0]  badFn[8] = '{8'h00, 8'h02, 8'h03, 8'h05, 8'h06, 8'h0f,
                              8'h10, 8'h17};
    int          badSt[8] = '{'h39, 0, 'h38, 'h800, 'h7ff, 'h871, 'h7fe,
                              'h86f};
    int          badN[8]  = '{1, 0, 2, 2, 3, 1, 2, 4};

    always #2.5 sys_clk = ~sys_clk;

    coil_status_change_detect u_coil_status_change_detect (
        .sys_clk(sys_clk), .resetn(resetn), .elementPin(elementPin),
        .latchEnable(latchEnable), .keyClearPin(keyClearPin),
        .keyEnterPin(keyEnterPin), .remoteClearValid(remoteClearValid),
        .remoteClearMask(remoteClearMask), .reqValid(reqValid),
        .reqFunction(reqFunction), .reqStart(reqStart),
        .reqCount(reqCount), .reqReady(reqReady), .rspValid(rspValid),
        .rspBit(rspBit), .rspLast(rspLast), .rspException(rspException),
        .rspExceptionCode(rspExceptionCode));

    coil_host_model u_coil_host_model (
        .sys_clk(sys_clk), .reqReady(reqReady), .reqValid(reqValid),
        .reqFunction(reqFunction), .reqStart(reqStart),
        .reqCount(reqCount), .remoteClearValid(remoteClearValid),
        .remoteClearMask(remoteClearMask));

    // ****************************************************************
    // Checking
    // ****************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] want,
                         input string what);
        checks++;
        if (seen !== want) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s seen %h want %h", $time,
                     what, seen, want);
        end
    endtask : check

    task automatic tally_and_finish;
        if (notes.size() != 0) begin
            fail_count++;
            $display("CHECK FAILED at %0t: replies missing", $time);
        end
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    always @(negedge sys_clk) begin
        if (rspValid === 1'b1) begin
            if (notes.size() == 0) begin
                check(8'h01, 8'h00, "reply without request");
            end else begin
                got = notes.pop_front();
                check({7'h0, rspException}, {7'h0, got.exc}, "exc");
                check({7'h0, rspLast}, {7'h0, got.last}, "last");
                if (got.exc)
                    check(rspExceptionCode, got.code, "code");
                else
                    check({7'h0, rspBit}, {7'h0, got.bitVal}, "bit");
            end
        end
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            tally_and_finish;
        end
    end

    // ****************************************************************
    // Reference of the coil space
    // ****************************************************************
    // pair layout
    function automatic logic coil(input int a);
        int off;
        off = a - coil_pkg::CD_FIRST_ADDR;
        if (a <= coil_pkg::RT_LAST_ADDR)
            return latchEnable[a] ? (lat[a] | cur[a]) : cur[a];
        if (off % 2 == 0)
            return cnt[off / 2] >= 2;
        return cur[off / 2];
    endfunction : coil

    task automatic ask(input logic [7:0] fn, input int st, input int n);
        bit good, inCd, busy;
        int a;
        inCd = n > 0 && st >= coil_pkg::CD_FIRST_ADDR && n % 2 == 0
               && st + n - 1 <= coil_pkg::CD_LAST_ADDR
               && (st - coil_pkg::CD_FIRST_ADDR) % 2 == 0;
        good = inCd || (n > 0 && st + n - 1 <= coil_pkg::RT_LAST_ADDR);
        if (fn !== coil_pkg::FUNC_READ_COIL)
            notes.push_back('{1'b1, 1'b0, 1'b1, coil_pkg::EXC_BAD_FUNC});
        else if (!good)
            notes.push_back('{1'b1, 1'b0, 1'b1, coil_pkg::EXC_BAD_ADDR});
        else
            for (a = st; a < st + n; a++)
                notes.push_back('{1'b0, coil(a), a == st + n - 1, 8'h00});
        busy = good && fn === coil_pkg::FUNC_READ_COIL;
        u_coil_host_model.read(fn, st[15:0], n[15:0]);
        // A data reply keeps the request side closed while it streams.
        check({7'h0, reqReady}, {7'h0, !busy}, "ready");
        if (inCd && fn === coil_pkg::FUNC_READ_COIL)
            for (a = st; a < st + n; a += 2)
                cnt[(a - coil_pkg::CD_FIRST_ADDR) / 2] = 0;
        for (a = 0; a < 400 && notes.size() > 0; a++) @(negedge sys_clk);
        repeat (2) @(negedge sys_clk);
    endtask : ask

    task automatic apply(input logic [56:0] v);
        int j;
        @(negedge sys_clk);
        elementPin = v;
        for (j = 0; j < 57; j++) begin
            if (v[j] !== cur[j] && cnt[j] < 2)
                cnt[j]++;
            if (v[j] && !cur[j] && latchEnable[j])
                lat[j] = 1'b1;
        end
        cur = v;
        repeat (4) @(negedge sys_clk);
    endtask : apply

    task automatic press(input logic c, input logic e);
        @(negedge sys_clk);
        keyClearPin = c;
        keyEnterPin = e;
        repeat (4) @(negedge sys_clk);
        keyClearPin = 1'b0;
        keyEnterPin = 1'b0;
        repeat (4) @(negedge sys_clk);
        if (c && e)
            lat = '0;
    endtask : press

    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        elementPin = '0;
        latchEnable = '0;
        keyClearPin = 1'b0;
        keyEnterPin = 1'b0;
        cur = '0;
        lat = '0;
        seed = 32'ha735;
        foreach (cnt[j]) cnt[j] = 0;
        repeat (8) @(negedge sys_clk);
        resetn = 1'b1;
        r = {$random(seed), $random(seed)};
        latchEnable = r[56:0];
        repeat (2) @(negedge sys_clk);
        foreach (badFn[j]) ask(badFn[j], 0, 1);
        foreach (badSt[j]) ask(8'h01, badSt[j], badN[j]);
        for (i = 0; i < 6; i++) begin
            r = {$random(seed), $random(seed)};
            apply(r[56:0]);
            r = {$random(seed), $random(seed)};
            apply(r[56:0]);
            ask(8'h01, 0, 57);
            k = $random(seed) & 31;
            ask(8'h01, coil_pkg::CD_FIRST_ADDR + 2 * k, 2 + 2 * (i % 3));
        end
        repeat (2) ask(8'h01, coil_pkg::CD_FIRST_ADDR, 114);
        r = {$random(seed), $random(seed)};
        apply(r[56:0]);
        apply('0);
        press(1'b1, 1'b0);
        ask(8'h01, 0, 57);
        press(1'b1, 1'b1);
        ask(8'h01, 0, 57);
        r = {$random(seed), $random(seed)};
        apply(r[56:0]);
        apply('0);
        r = {$random(seed), $random(seed)};
        u_coil_host_model.clear_bits(r[56:0]);
        lat = lat & ~r[56:0];
        repeat (2) @(negedge sys_clk);
        ask(8'h01, 0, 57);
        ask(8'h01, coil_pkg::RT_LAST_ADDR, 1);
        ask(8'h01, coil_pkg::CD_LAST_ADDR - 1, 2);
        tally_and_finish;
    end
endmodule : tb
